// >>> verilog/ricr_regs.sv
// Purpose: Reference input priority and monitor configuration registers
// Assumes: AHB-Lite single word transfers, zero wait states, OKAY only
// Notes: Priority register has separate main-path and aux-path views
module ricr_regs (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic [ricr_pkg::RICR_PRIO_W-1:0] in13_main_prio,
    output logic in13_main_enabled,
    output logic [ricr_pkg::RICR_PRIO_W-1:0] in13_aux_prio,
    output logic [ricr_pkg::RICR_NUM_CFG-1:0] in1_monitor_cfg_sel,
    output logic [ricr_pkg::RICR_NUM_CFG-1:0] in2_monitor_cfg_sel
);
    import ricr_pkg::*;

    // Reset images of the derived outputs, worked out from the register
    // reset values so that the two can never drift apart
    localparam logic EN13_RST =
        RICR_RST_RANK_MAIN[RICR_PRIO_W-1:0] != RICR_PRIO_OFF;
    localparam logic [RICR_NUM_CFG-1:0] PICK_RST =
        RICR_NUM_CFG'(1) << RICR_RST_SETUP[RICR_PICK_LSB +: RICR_PICK_W];

    // Does this index name a mapped register
    function automatic logic is_mapped(input logic [RICR_IDX_W-1:0] idx);
        is_mapped = (idx == RICR_IDX_RANK_13_14) ||
            (idx == RICR_IDX_IN1_SETUP) || (idx == RICR_IDX_IN2_SETUP) ||
            (idx == RICR_IDX_VIEW_CTRL) || (idx == RICR_IDX_MON_STATUS);
    endfunction

    ricr_state_t state_q, state_d;
    logic [RICR_IDX_W-1:0] idx_q, idx_d;
    logic wr_q, wr_d;
    logic [7:0] rank_main_q, rank_main_d;
    logic [7:0] rank_aux_q, rank_aux_d;
    logic [7:0] in1_q, in1_d;
    logic [7:0] in2_q, in2_d;
    logic [7:0] view_q, view_d;
    logic [31:0] rdata_q, rdata_d;
    logic [RICR_PRIO_W-1:0] p13m_q, p13m_d, p13a_q, p13a_d;
    logic en13_q, en13_d;
    logic [RICR_NUM_CFG-1:0] pick1_q, pick2_q;
    logic [RICR_NUM_CFG-1:0] pick1_w, pick2_w;
    logic take;
    logic [7:0] wbyte;
    logic aux_view;

    // Accept only valid word transfers while the bus is ready
    assign take = hsel && hready && (htrans == RICR_HTRANS_NONSEQ ||
        htrans == RICR_HTRANS_SEQ) && (hsize == RICR_HSIZE_WORD);
    assign wbyte = hwdata[7:0];
    assign aux_view = view_q[RICR_VIEW_BIT];

    // Address phase capture; data phase completes with no wait state
    always_comb begin
        state_d = RICR_ST_IDLE;
        idx_d = idx_q;
        wr_d = 1'b0;
        if (take) begin
            state_d = RICR_ST_DATA;
            idx_d = haddr[RICR_IDX_LSB +: RICR_IDX_W];
            wr_d = hwrite;
        end
    end

    // Register writes in the data phase
    always_comb begin
        rank_main_d = rank_main_q;
        rank_aux_d = rank_aux_q;
        in1_d = in1_q;
        in2_d = in2_q;
        view_d = view_q;
        if (state_q == RICR_ST_DATA && wr_q) begin
            case (idx_q)
                RICR_IDX_RANK_13_14: begin
                    if (aux_view) begin
                        rank_aux_d = wbyte;
                    end else begin
                        rank_main_d = wbyte;
                    end
                end
                RICR_IDX_IN1_SETUP: in1_d = wbyte;
                RICR_IDX_IN2_SETUP: in2_d = wbyte;
                RICR_IDX_VIEW_CTRL: view_d = wbyte;
                default: ;
            endcase
        end
    end

    // Read data for the next data phase; monitor status is read-only
    always_comb begin
        rdata_d = '0;
        if (take && !hwrite) begin
            case (haddr[RICR_IDX_LSB +: RICR_IDX_W])
                RICR_IDX_RANK_13_14:
                    rdata_d[7:0] = aux_view ? rank_aux_q : rank_main_q;
                RICR_IDX_IN1_SETUP: rdata_d[7:0] = in1_q;
                RICR_IDX_IN2_SETUP: rdata_d[7:0] = in2_q;
                RICR_IDX_VIEW_CTRL: rdata_d[7:0] = view_q;
                RICR_IDX_MON_STATUS:
                    rdata_d[7:0] = {pick2_q, pick1_q};
                default: rdata_d = '0;
            endcase
        end
    end

    always_comb begin
        p13m_d = rank_main_q[RICR_PRIO_W-1:0];
        p13a_d = rank_aux_q[RICR_PRIO_W-1:0];
        en13_d = (rank_main_q[RICR_PRIO_W-1:0] != RICR_PRIO_OFF);
    end

    ricr_cfg_pick u_pick1 (
        .sel(in1_q[RICR_PICK_LSB +: RICR_PICK_W]),
        .onehot(pick1_w)
    );
    ricr_cfg_pick u_pick2 (
        .sel(in2_q[RICR_PICK_LSB +: RICR_PICK_W]),
        .onehot(pick2_w)
    );

    // All state registered; reset loads documented defaults
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= RICR_ST_IDLE;
            idx_q <= '0;
            wr_q <= 1'b0;
            rank_main_q <= RICR_RST_RANK_MAIN;
            rank_aux_q <= RICR_RST_RANK_AUX;
            in1_q <= RICR_RST_SETUP;
            in2_q <= RICR_RST_SETUP;
            view_q <= RICR_RST_VIEW;
            rdata_q <= '0;
            p13m_q <= RICR_RST_RANK_MAIN[RICR_PRIO_W-1:0];
            p13a_q <= RICR_RST_RANK_AUX[RICR_PRIO_W-1:0];
            en13_q <= EN13_RST;
            pick1_q <= PICK_RST;
            pick2_q <= PICK_RST;
        end else begin
            state_q <= state_d;
            idx_q <= idx_d;
            wr_q <= wr_d;
            rank_main_q <= rank_main_d;
            rank_aux_q <= rank_aux_d;
            in1_q <= in1_d;
            in2_q <= in2_d;
            view_q <= view_d;
            rdata_q <= rdata_d;
            p13m_q <= p13m_d;
            p13a_q <= p13a_d;
            en13_q <= en13_d;
            pick1_q <= pick1_w;
            pick2_q <= pick2_w;
        end
    end

    // Outputs straight from flops, hreadyout and hresp tied off; zero wait, always OKAY
    assign hrdata = rdata_q;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign in13_main_prio = p13m_q;
    assign in13_aux_prio = p13a_q;
    assign in13_main_enabled = en13_q;
    assign in1_monitor_cfg_sel = pick1_q;
    assign in2_monitor_cfg_sel = pick2_q;

    // Unmapped index in an address phase; a miss needs no logic of its own,
    // the zero default of the read mux already covers it
    logic unmapped_hit;
    assign unmapped_hit = take &&
        !is_mapped(haddr[RICR_IDX_LSB +: RICR_IDX_W]);

    // Checks share one clock; reset cancels every attempt in flight, so
    // the reset checks below override the disable on purpose
    default clocking cb_chk @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // Data phase of a write to the rank, input 1 setup and input 2 setup registers
    sequence s_rank_write;
        state_q == RICR_ST_DATA && wr_q && idx_q == RICR_IDX_RANK_13_14;
    endsequence
    sequence s_in1_write;
        state_q == RICR_ST_DATA && wr_q && idx_q == RICR_IDX_IN1_SETUP;
    endsequence
    sequence s_in2_write;
        state_q == RICR_ST_DATA && wr_q && idx_q == RICR_IDX_IN2_SETUP;
    endsequence
    // Address phase of a read
    sequence s_read_addr;
        take && !hwrite;
    endsequence

    a_prio_zero_off: assert property (
        rank_main_q[RICR_PRIO_W-1:0] == RICR_PRIO_OFF |=> !in13_main_enabled)
        else $error("zero priority left input enabled");
    a_prio_nonzero_on: assert property (
        rank_main_q[RICR_PRIO_W-1:0] != RICR_PRIO_OFF |=> in13_main_enabled)
        else $error("nonzero priority left input disabled");
    a_prio_field_copy: assert property (
        1'b1 |=> in13_main_prio == $past(rank_main_q[RICR_PRIO_W-1:0]))
        else $error("input 13 priority not copied");
    a_aux_field_copy: assert property (
        1'b1 |=> in13_aux_prio == $past(rank_aux_q[RICR_PRIO_W-1:0]))
        else $error("input 13 aux priority not copied");

    a_rank_reset_vals: assert property (disable iff (1'b0)
        !hresetn |=> rank_main_q == RICR_RST_RANK_MAIN &&
        rank_aux_q == RICR_RST_RANK_AUX)
        else $error("rank reset value wrong");
    a_aux_write_only: assert property (
        s_rank_write ##0 aux_view |=> $stable(rank_main_q))
        else $error("aux view write changed main view");
    a_main_write_only: assert property (
        s_rank_write ##0 !aux_view |=> $stable(rank_aux_q))
        else $error("main view write changed aux view");
    a_main_write_store: assert property (
        s_rank_write ##0 !aux_view |=> rank_main_q == $past(wbyte))
        else $error("main view write not stored");
    a_rank_view_read: assert property (
        s_read_addr ##0
        haddr[RICR_IDX_LSB +: RICR_IDX_W] == RICR_IDX_RANK_13_14 |=>
        hrdata[7:0] == $past(aux_view ? rank_aux_q : rank_main_q))
        else $error("rank read ignored the view select");

    a_setup_reset_vals: assert property (disable iff (1'b0)
        !hresetn |=> in1_q == RICR_RST_SETUP && in2_q == RICR_RST_SETUP)
        else $error("setup reset value wrong");
    a_in1_write_store: assert property (
        s_in1_write |=> in1_q == $past(wbyte))
        else $error("input 1 write not stored");

    a_in1_pick_map: assert property (
        1'b1 |=> in1_monitor_cfg_sel ==
        (RICR_NUM_CFG'(1) << $past(in1_q[RICR_PICK_LSB +: RICR_PICK_W])))
        else $error("input 1 pick mismatch");

    a_in2_write_store: assert property (
        s_in2_write |=> in2_q == $past(wbyte))
        else $error("input 2 write not stored");
    a_in2_pick_map: assert property (
        1'b1 |=> in2_monitor_cfg_sel ==
        (RICR_NUM_CFG'(1) << $past(in2_q[RICR_PICK_LSB +: RICR_PICK_W])))
        else $error("input 2 pick mismatch");

    a_pick_onehot: assert property (
        $onehot(in1_monitor_cfg_sel) && $onehot(in2_monitor_cfg_sel))
        else $error("monitor pick not one-hot");
    a_pick_reset_vals: assert property (disable iff (1'b0)
        !hresetn |=> in1_monitor_cfg_sel == PICK_RST &&
        in2_monitor_cfg_sel == PICK_RST)
        else $error("monitor pick reset value wrong");

    // Unmapped index reads as zero
    a_unmapped_zero: assert property (
        unmapped_hit && !hwrite |=> hrdata == '0)
        else $error("unmapped read not zero");
    // Read data stands for one data phase only
    a_rdata_idle_zero: assert property (
        !(take && !hwrite) |=> hrdata == '0)
        else $error("read data left standing");
    // Zero wait states and an OKAY answer on every cycle
    a_bus_okay_ready: assert property (
        hreadyout && !hresp)
        else $error("slave stalled or answered with an error");
endmodule // ricr_regs

// >>> verilog/ricr_pkg.sv
// Purpose: Shared constants for the reference input configuration bank
// Assumes: AHB-Lite slave, 32-bit data, one register per aligned word
// Notes: Register offsets are word indices, not byte addresses
package ricr_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] RICR_IDX_RANK_13_14 = 8'h1E;
    localparam logic [7:0] RICR_IDX_IN1_SETUP = 8'h20;
    localparam logic [7:0] RICR_IDX_IN2_SETUP = 8'h21;
    localparam logic [7:0] RICR_IDX_VIEW_CTRL = 8'h4B;
    localparam logic [7:0] RICR_IDX_MON_STATUS = 8'h80;
    localparam int RICR_IDX_LSB = 2;
    localparam int RICR_IDX_W = 8;
    // Reset values per register; the rank register has one per view
    localparam logic [7:0] RICR_RST_RANK_MAIN = 8'hFE;
    localparam logic [7:0] RICR_RST_RANK_AUX = 8'h00;
    localparam logic [7:0] RICR_RST_SETUP = 8'h00;
    localparam logic [7:0] RICR_RST_VIEW = 8'h00;
    // Field layout
    localparam int RICR_PICK_LSB = 4;
    localparam int RICR_PICK_W = 2;
    localparam int RICR_PRIO_W = 4;
    localparam int RICR_VIEW_BIT = 4;
    localparam int RICR_NUM_CFG = 4;
    localparam logic [3:0] RICR_PRIO_OFF = 4'h0;
    // AHB-Lite codes
    localparam logic [1:0] RICR_HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] RICR_HTRANS_SEQ = 2'h3;
    localparam logic [2:0] RICR_HSIZE_WORD = 3'h2;
    typedef enum logic [1:0] {
        RICR_ST_IDLE = 2'b01,
        RICR_ST_DATA = 2'b10
    } ricr_state_t;
endpackage

// >>> verilog/ricr_cfg_pick.sv
// Purpose: Turn a two-bit selector into a one-hot monitor configuration pick
// Assumes: Selector comes from a register in the same clock domain
// Notes: Combinational; the parent registers the result
module ricr_cfg_pick (
    input wire logic [ricr_pkg::RICR_PICK_W-1:0] sel,
    output logic [ricr_pkg::RICR_NUM_CFG-1:0] onehot
);
    import ricr_pkg::*;
    // One bit per shared leaky-bucket configuration
    always_comb begin
        onehot = '0;
        onehot[sel] = 1'b1;
    end
endmodule // ricr_cfg_pick

// >>> dv/test_ricr_regs.sv
// Purpose: Self-checking bench for the reference input config registers
// Assumes: Zero-wait AHB-Lite slave, hready looped back from hreadyout
// Notes: Read data is captured at the edge, then used 1 ns later
module test_ricr_regs;
    timeunit 1ns;
    timeprecision 1ps;
    import ricr_pkg::*;
    typedef struct {logic [31:0] a; logic [7:0] d; logic [3:0] s1;
        logic [3:0] s2;} ricr_row_t;
    localparam logic [31:0] A_RANK = {22'h0, RICR_IDX_RANK_13_14, 2'h0};
    localparam logic [31:0] A_IN1 = {22'h0, RICR_IDX_IN1_SETUP, 2'h0};
    localparam logic [31:0] A_IN2 = {22'h0, RICR_IDX_IN2_SETUP, 2'h0};
    localparam logic [31:0] A_VIEW = {22'h0, RICR_IDX_VIEW_CTRL, 2'h0};
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    wire logic hready;
    logic [31:0] hrdata, rd_smp;
    logic hreadyout, hresp, en13, resp_smp;
    logic [3:0] p_main, p_aux, sel1, sel2;
    int n_errors = 0;
    int tests_run = 0;
    ricr_row_t rows [8];
    // Single slave, so its ready is the bus ready
    assign hready = hreadyout;
    always #4 hclk = ~hclk;
    // Capture before the edge updates land, avoiding a read race
    always @(posedge hclk) begin
        rd_smp <= hrdata;
        resp_smp <= hresp;
    end
    ricr_regs dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .in13_main_prio(p_main),
        .in13_main_enabled(en13), .in13_aux_prio(p_aux),
        .in1_monitor_cfg_sel(sel1), .in2_monitor_cfg_sel(sel2));
    // Verdict and end of run
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk_rd(string nm, logic [7:0] e, logic [31:0] g);
        tests_run++;
        if (g !== {24'h0, e}) begin
            n_errors++;
            $display("BAD %s exp %h got %h", nm, {24'h0, e}, g);
        end
    endtask
    task automatic chk_pin(string nm, logic [3:0] e, logic [3:0] g);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    // Bounded wait for hready at a rising edge
    task automatic wait_rdy();
        int k;
        k = 0;
        @(posedge hclk);
        while (hready !== 1'b1 && k < 100) begin
            @(posedge hclk);
            k++;
        end
        if (hready !== 1'b1) begin
            n_errors++;
            wrap_up();
        end
    endtask
    // One single word transfer: address phase, then data phase
    task automatic bus(logic wr, logic [31:0] a, logic [7:0] d);
        // Launch the request on a rising edge, never between edges
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        hsize <= RICR_HSIZE_WORD;
        htrans <= RICR_HTRANS_NONSEQ;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        wait_rdy();
        #1;
    endtask
    task automatic rd_chk(string nm, logic [31:0] a, logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk_rd(nm, e, rd_smp);
        chk_pin("hresp", 4'h0, {3'h0, resp_smp});
    endtask
    // Derived outputs trail the register by one edge
    task automatic settle();
        @(posedge hclk);
        #1;
    endtask
    initial begin
        rows = '{'{A_IN1, 8'h00, 4'h1, 4'h1}, '{A_IN1, 8'h10, 4'h2, 4'h1},
            '{A_IN1, 8'h20, 4'h4, 4'h1}, '{A_IN1, 8'h30, 4'h8, 4'h1},
            '{A_IN2, 8'h20, 4'h8, 4'h4}, '{A_IN2, 8'h30, 4'h8, 4'h8},
            '{A_IN2, 8'h10, 4'h8, 4'h2}, '{A_IN2, 8'h00, 4'h8, 4'h1}};
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        settle();
        chk_pin("main_prio", 4'hE, p_main);
        chk_pin("enabled", 4'h1, {3'h0, en13});
        chk_pin("aux_prio", 4'h0, p_aux);
        chk_pin("sel1", 4'h1, sel1);
        chk_pin("sel2", 4'h1, sel2);
        rd_chk("rank", A_RANK, 8'hFE);
        rd_chk("in1", A_IN1, 8'h00);
        rd_chk("in2", A_IN2, 8'h00);
        $display("test reset done");
        foreach (rows[i]) begin
            bus(1'b1, rows[i].a, rows[i].d);
            settle();
            chk_pin("sel1", rows[i].s1, sel1);
            chk_pin("sel2", rows[i].s2, sel2);
            rd_chk("setup", rows[i].a, rows[i].d);
        end
        $display("test picks done");
        bus(1'b1, A_RANK, 8'h40);
        settle();
        chk_pin("main_prio", 4'h0, p_main);
        chk_pin("enabled", 4'h0, {3'h0, en13});
        bus(1'b1, A_RANK, 8'h01);
        settle();
        chk_pin("enabled", 4'h1, {3'h0, en13});
        bus(1'b1, A_VIEW, 8'h10);
        rd_chk("rank_aux", A_RANK, 8'h00);
        bus(1'b1, A_RANK, 8'h0F);
        settle();
        chk_pin("aux_prio", 4'hF, p_aux);
        chk_pin("main_prio", 4'h1, p_main);
        bus(1'b1, A_VIEW, 8'h00);
        rd_chk("rank_main", A_RANK, 8'h01);
        $display("test priority done");
        // Unmapped index ignores the write and reads zero
        bus(1'b1, 32'h40, 8'h5A);
        rd_chk("unmapped", 32'h40, 8'h00);
        $display("test unmapped done");
        // second reset in mid-run, from non-reset contents
        bus(1'b1, A_IN2, 8'h30);
        settle();
        chk_pin("sel2", 4'h8, sel2);
        @(posedge hclk);
        hresetn <= 1'b0;
        settle();
        chk_pin("sel2", 4'h1, sel2);
        chk_pin("main_prio", 4'hE, p_main);
        chk_pin("enabled", 4'h1, {3'h0, en13});
        @(posedge hclk);
        hresetn <= 1'b1;
        settle();
        rd_chk("in2", A_IN2, 8'h00);
        rd_chk("rank", A_RANK, 8'hFE);
        $display("test reset2 done");
        wrap_up();
    end
endmodule // test_ricr_regs
